// ==== pkg/converter_config_consts.svh ====
// Purpose: named constants for the converter configuration commands
// Assumes: linear words carry exponent in 15:11, mantissa in 10:0
// Notes: fixed-point values carry 16 fraction bits in 48 bits
`ifndef CONVERTER_CONFIG_CONSTS_SVH
`define CONVERTER_CONFIG_CONSTS_SVH

`define CMD_SCALE 8'h29
`define CMD_FLOOR 8'h2b
`define CMD_RATE 8'h33
`define CMD_INPUT_START_THRESHOLD 8'h35

`define EXP_MSB 15
`define EXP_LSB 11
`define MAN_MSB 10

`define SCALE_EXP_RST 5'h19
`define VIN_EXP_RST 5'h1e
`define WORD_RST 16'h0000

`define FIX_ZERO 48'h0000_0000_0000
`define FIX_EIGHTH 48'h0000_0000_2000
`define FIX_QUARTER 48'h0000_0000_4000
`define FIX_HALF 48'h0000_0000_8000
`define FIX_ONE 48'h0000_0001_0000
`define FIX_FRAC 16'h0000
`define FIX_SIGN 47

// band edges in kHz, lowest edge in the low slice
`define RATE_LIMITS {11'h672, 11'h578, 11'h4b0, 11'h3e8, 11'h334, 11'h2bc, \
  11'h258, 11'h1f4, 11'h19a, 11'h15e, 11'h12c, 11'h0fa}
`define RATE_BANDS 11
`define RATE_TOP 11
`define RATE_MAN_MAX 11'h3ff
`define RATE_EXP_ZERO 5'h00
`define RATE_EXP_ONE 5'h01
`define RATE_LOW_FIX 48'h0000_00fa_0000

`define VIN_MAX_FIX 48'h0000_000f_c000
`define VIN_Q_LSB 14
`define VIN_Q_MIN 6'h0a
`define VIN_CODE_MAX 6'h35
`define VIN_CODE_ZERO 6'h00

`endif

// ==== pkg/converter_config_pkg.sv ====
// Purpose: types shared by the converter configuration block
// Assumes: one controller clock
// Notes: command port carries one PMBus word access per valid cycle
package converter_config_pkg;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_req_t;

  typedef struct packed {
    logic [10:0] scale_man;
    logic [10:0] rate_khz;
    logic [10:0] vin_man;
    logic [15:0] floor;
  } nvm_t;

  typedef struct packed {
    logic nota;
    logic word_vout;
    logic vout_minmax;
    logic cml_data;
  } status_t;

  typedef enum logic [1:0] {
    TAP_EIGHTH = 2'b00,
    TAP_QUARTER = 2'b01,
    TAP_HALF = 2'b10,
    TAP_FULL = 2'b11
  } div_tap_t;

endpackage : converter_config_pkg

// ==== rtl/converter_config_commands.sv ====
// Purpose: feedback scale, output floor, switching rate, input start commands
// Assumes: command port synchronous to SYS_CLK, NVM image stable
// Notes: NVM image is loaded on the first cycle after reset and on RESTORE
//
// Functional notes
// - scale and rate use signed linear words
// - scale exponent resets to 11001, mantissa from NVM
// - scale/rate hardware updates only while not converting or on NVM load
// - scale value selects internal divider tap
// - in-range values read back exactly as written
// - decoded scale quantized to four divider factors
// - reference ratio uses written scale, not tap
// - out-of-range write flags invalid data, alerts host
// - floor is unsigned absolute 16-bit word
// - floor limits every commanded output target
// - target below floor warns while converting, output ramps to floor
// - floor warning sets three status bits, alerts
// - conflicting ceiling gives the same warning
// - floor valid range equals ceiling range
// - rate in kHz, exponent regenerated at reset
// - decoded rate quantized to twelve frequencies
// - start threshold is signed linear volts word
// - start threshold exponent resets to 11110
// - start threshold 2.50 to 15.75 V, rounded down
`timescale 1ns/100ps
`include "converter_config_consts.svh"

module converter_config_commands
  import converter_config_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire cmd_req_t CMD,
  input wire nvm_t NVM,
  input wire logic RESTORE,
  input wire logic CONV_EN,
  input wire logic [15:0] TARGET_REQ,
  input wire logic [15:0] SLEW_STEP,
  input wire logic [15:0] VOUT_MAX,
  input wire logic MAX_WRITE,
  input wire logic CLEAR_FAULTS,
  output logic [15:0] RD_DATA,
  output logic RD_VALID,
  output div_tap_t DIV_TAP,
  output logic [15:0] SCALE_WORD,
  output logic [3:0] RATE_SEL,
  output logic [5:0] VIN_CODE,
  output logic [15:0] VOUT_TARGET,
  output status_t STATUS,
  output logic ALERT
);

  // exponent + 16 is the exponent with its sign bit flipped
  function automatic logic signed [47:0] lin_fix(input logic [15:0] w);
    logic signed [47:0] m;
    logic [4:0] sh;
    m = 48'(signed'(w[`MAN_MSB:0]));
    sh = {~w[`EXP_MSB], w[`EXP_MSB-1:`EXP_LSB]};
    lin_fix = m <<< sh;
  endfunction : lin_fix

  logic [15:0] scale_ff, floor_ff, rate_ff, vin_ff;
  logic [15:0] nxt_scale, nxt_floor, nxt_rate, nxt_vin;
  logic load_pend_ff;
  logic [15:0] prev_req_ff;
  logic [15:0] rd_data_ff;
  logic rd_valid_ff;
  div_tap_t div_tap_ff;
  logic [15:0] scale_word_ff;
  logic [3:0] rate_sel_ff;
  logic [5:0] vin_code_ff;
  logic [15:0] vout_ff;
  status_t status_ff, nxt_status;
  logic alert_ff;

  wire cmd_wr = CMD.valid & CMD.write;
  wire cmd_rd = CMD.valid & ~CMD.write;
  wire hit_scale = CMD.code == `CMD_SCALE;
  wire hit_floor = CMD.code == `CMD_FLOOR;
  wire hit_rate = CMD.code == `CMD_RATE;
  wire hit_vin = CMD.code == `CMD_INPUT_START_THRESHOLD;
  wire hit_any = hit_scale | hit_floor | hit_rate | hit_vin;

  wire signed [47:0] fix_w = lin_fix(CMD.wdata);
  wire scale_ok = (fix_w > `FIX_ZERO) && (fix_w <= `FIX_ONE);
  wire rate_ok = (fix_w > `FIX_ZERO) && (fix_w < 48'({11'(`RATE_LIMITS >> (`RATE_TOP * 11)), `FIX_FRAC}));
  wire vin_ok = !fix_w[`FIX_SIGN] && (fix_w <= `VIN_MAX_FIX);
  wire floor_ok = CMD.wdata <= VOUT_MAX;

  wire wr_scale = cmd_wr & hit_scale & scale_ok;
  wire wr_floor = cmd_wr & hit_floor & floor_ok;
  wire wr_rate = cmd_wr & hit_rate & rate_ok;
  wire wr_vin = cmd_wr & hit_vin & vin_ok;
  wire wr_good = wr_scale | wr_floor | wr_rate | wr_vin;
  wire bad_wr = cmd_wr & ~wr_good;
  wire bad_rd = cmd_rd & ~hit_any;

  wire nvm_load = load_pend_ff | RESTORE;
  wire hw_upd = nvm_load | ~CONV_EN;

  wire [15:0] rate_regen = (NVM.rate_khz > `RATE_MAN_MAX) ?
    {`RATE_EXP_ONE, 1'b0, NVM.rate_khz[10:1]} :
    {`RATE_EXP_ZERO, NVM.rate_khz};

  // rejected writes fall through to the held value
  assign nxt_scale = nvm_load ? {`SCALE_EXP_RST, NVM.scale_man} :
    (wr_scale ? CMD.wdata : scale_ff);
  assign nxt_rate = nvm_load ? rate_regen :
    (wr_rate ? CMD.wdata : rate_ff);
  assign nxt_vin = nvm_load ? {`VIN_EXP_RST, NVM.vin_man} :
    (wr_vin ? CMD.wdata : vin_ff);
  assign nxt_floor = nvm_load ? NVM.floor :
    (wr_floor ? CMD.wdata : floor_ff);

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      scale_ff <= {`SCALE_EXP_RST, 11'h000};
      rate_ff <= `WORD_RST;
      vin_ff <= {`VIN_EXP_RST, 11'h000};
      floor_ff <= `WORD_RST;
      load_pend_ff <= 1'b1;
    end else begin
      scale_ff <= nxt_scale;
      rate_ff <= nxt_rate;
      vin_ff <= nxt_vin;
      floor_ff <= nxt_floor;
      load_pend_ff <= 1'b0;
    end
  end

  // hardware decode of the next stored values
  wire signed [47:0] fix_s = lin_fix(nxt_scale);
  wire signed [47:0] fix_r = lin_fix(nxt_rate);
  wire signed [47:0] fix_v = lin_fix(nxt_vin);

  wire div_tap_t tap_nxt = (fix_s <= `FIX_EIGHTH) ? TAP_EIGHTH :
    (fix_s <= `FIX_QUARTER) ? TAP_QUARTER :
    (fix_s <= `FIX_HALF) ? TAP_HALF : TAP_FULL;

  localparam logic [131:0] RATE_EDGE = `RATE_LIMITS;
  logic [`RATE_BANDS-1:0] rate_above;
  genvar gi;
  generate
    for (gi = 0; gi < `RATE_BANDS; gi++) begin : g_band
      assign rate_above[gi] = fix_r >= 48'({RATE_EDGE[gi*11 +: 11], `FIX_FRAC});
    end
  endgenerate

  logic [3:0] rate_band;
  always_comb begin
    rate_band = 4'h0;
    for (int i = 0; i < `RATE_BANDS; i++) begin
      rate_band = rate_band + 4'(rate_above[i]);
    end
  end

  // quarter-volt count, floored, then offset to the 2.50 V base
  wire [5:0] vin_q = fix_v[`VIN_Q_LSB +: 6];
  // range checks first, the six-bit count wraps above the top threshold
  wire [5:0] vin_code = fix_v[`FIX_SIGN] ? `VIN_CODE_ZERO :
    (fix_v > `VIN_MAX_FIX) ? `VIN_CODE_MAX :
    (vin_q < `VIN_Q_MIN) ? `VIN_CODE_ZERO : vin_q - `VIN_Q_MIN;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      div_tap_ff <= TAP_FULL;
      scale_word_ff <= `WORD_RST;
      rate_sel_ff <= 4'h0;
      vin_code_ff <= `VIN_CODE_ZERO;
    end else begin
      if (hw_upd) begin
        div_tap_ff <= tap_nxt;
        scale_word_ff <= nxt_scale;
        rate_sel_ff <= rate_band;
      end
      vin_code_ff <= vin_code;
    end
  end

  // floor clamp and ramp of the commanded output
  wire [15:0] goal = (TARGET_REQ < floor_ff) ? floor_ff : TARGET_REQ;
  wire [16:0] up_sum = {1'b0, vout_ff} + {1'b0, SLEW_STEP};
  wire [16:0] dn_dif = {1'b0, vout_ff} - {1'b0, SLEW_STEP};
  wire [15:0] ramp_up = (up_sum >= {1'b0, goal}) ? goal : up_sum[15:0];
  wire [15:0] ramp_dn = (dn_dif[16] || dn_dif[15:0] <= goal) ? goal : dn_dif[15:0];
  wire [15:0] nxt_vout = ~CONV_EN ? goal :
    (vout_ff < goal) ? ramp_up : ramp_dn;

  wire floor_warn = CONV_EN & (((TARGET_REQ != prev_req_ff) & (TARGET_REQ < floor_ff)) |
    (wr_floor & (TARGET_REQ < CMD.wdata)));
  wire ceil_warn = MAX_WRITE & (VOUT_MAX < TARGET_REQ);
  wire warn = floor_warn | ceil_warn;

  // a set in the clear cycle wins
  always_comb begin
    nxt_status = status_ff;
    if (CLEAR_FAULTS) begin
      nxt_status = '0;
    end
    if (warn) begin
      nxt_status.nota = 1'b1;
      nxt_status.word_vout = 1'b1;
      nxt_status.vout_minmax = 1'b1;
    end
    if (bad_wr | bad_rd) begin
      nxt_status.cml_data = 1'b1;
    end
  end

  wire [15:0] rd_mux = hit_scale ? scale_ff :
    hit_floor ? floor_ff :
    hit_rate ? rate_ff :
    hit_vin ? vin_ff : `WORD_RST;

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      prev_req_ff <= `WORD_RST;
      vout_ff <= `WORD_RST;
      status_ff <= '0;
      alert_ff <= 1'b0;
      rd_data_ff <= `WORD_RST;
      rd_valid_ff <= 1'b0;
    end else begin
      prev_req_ff <= TARGET_REQ;
      vout_ff <= nxt_vout;
      status_ff <= nxt_status;
      alert_ff <= |nxt_status;
      rd_valid_ff <= cmd_rd;
      if (cmd_rd) begin
        rd_data_ff <= rd_mux;
      end
    end
  end

  assign RD_DATA = rd_data_ff;
  assign RD_VALID = rd_valid_ff;
  assign DIV_TAP = div_tap_ff;
  assign SCALE_WORD = scale_word_ff;
  assign RATE_SEL = rate_sel_ff;
  assign VIN_CODE = vin_code_ff;
  assign VOUT_TARGET = vout_ff;
  assign STATUS = status_ff;
  assign ALERT = alert_ff;

  a_bad_wr_keep: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (bad_wr && !nvm_load) |=> (scale_ff == $past(scale_ff) && rate_ff == $past(rate_ff)
      && vin_ff == $past(vin_ff) && floor_ff == $past(floor_ff)))
    else $error("rejected write changed a stored value");

  a_bad_wr_flag: assert property (@(posedge SYS_CLK) disable iff (RESET)
    bad_wr |=> (status_ff.cml_data && ALERT))
    else $error("invalid write not flagged");

  a_hw_blocked: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (CONV_EN && !nvm_load) |=> ($stable(div_tap_ff) && $stable(rate_sel_ff) && $stable(scale_word_ff)))
    else $error("hardware setting moved while converting");

  a_scale_readback: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_scale && !nvm_load) |=> (scale_ff == $past(CMD.wdata)))
    else $error("scale not stored as written");

  a_tap_eighth: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!CONV_EN && !nvm_load && wr_scale && fix_w <= `FIX_EIGHTH) |=> (div_tap_ff == TAP_EIGHTH))
    else $error("small scale did not pick the eighth tap");

  a_floor_clamp: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !CONV_EN |=> (vout_ff >= $past(floor_ff)))
    else $error("output target below floor");

  a_warn_flags: assert property (@(posedge SYS_CLK) disable iff (RESET)
    floor_warn |=> (status_ff.nota && status_ff.word_vout && status_ff.vout_minmax && ALERT))
    else $error("floor warning flags missing");

  a_ceil_warn: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (MAX_WRITE && VOUT_MAX < TARGET_REQ) |=> status_ff.vout_minmax)
    else $error("ceiling conflict not warned");

  a_scale_exp_rst: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $fell(RESET) |-> (scale_ff[`EXP_MSB:`EXP_LSB] == `SCALE_EXP_RST))
    else $error("scale exponent reset value wrong");

  a_vin_range: assert property (@(posedge SYS_CLK) disable iff (RESET)
    VIN_CODE <= `VIN_CODE_MAX)
    else $error("start threshold code out of range");

  a_ref_ratio: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!CONV_EN && !nvm_load && wr_scale) |=> (SCALE_WORD == $past(CMD.wdata)))
    else $error("ratio word differs from written scale");

  a_rate_low: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!CONV_EN && !nvm_load && wr_rate && fix_w < `RATE_LOW_FIX) |=> (RATE_SEL == 4'h0))
    else $error("low rate did not pick the lowest band");

  a_vin_exp_rst: assert property (@(posedge SYS_CLK) disable iff (RESET)
    $fell(RESET) |-> (vin_ff[`EXP_MSB:`EXP_LSB] == `VIN_EXP_RST))
    else $error("start threshold exponent reset value wrong");

  a_rd_unmapped: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (cmd_rd && !hit_any) |=> (RD_DATA == `WORD_RST && status_ff.cml_data))
    else $error("unmapped read not flagged");

  a_ramp_no_overshoot: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (CONV_EN && vout_ff <= goal) |=> (vout_ff <= $past(goal)))
    else $error("output ramp overshot its goal");

endmodule : converter_config_commands

// ==== verif/pmbus_host_model.sv ====
// Purpose: host side issuing word commands and holding the stored image
// Assumes: requests launched on the falling edge, held one cycle each
// Notes: blocked settings are applied by storing then reloading the image
`timescale 1ns/100ps
`include "converter_config_consts.svh"
module pmbus_host_model
  import converter_config_pkg::*;
(
  input wire logic SYS_CLK,
  output cmd_req_t CMD,
  output nvm_t NVM,
  output logic RESTORE
);
  // regulator rail fed externally, so rates above 1100 kHz are allowed
  localparam bit EXT_RAIL = 1'b1;
  initial begin
    CMD = '0;
    NVM = {11'h040, 11'h44c, 11'h028, 16'h0100};
    RESTORE = 1'b0;
  end
  task automatic op(input logic w, input logic [7:0] c, input logic [15:0] d);
    int khz;
    @(negedge SYS_CLK);
    khz = (d[`EXP_MSB] || d[`MAN_MSB]) ? 0 : int'(d[`MAN_MSB:0]) << d[`EXP_MSB-1:`EXP_LSB];
    // without an external rail, rate writes are capped at 1100 kHz
    if (!EXT_RAIL && w && c == `CMD_RATE && khz > 1100) begin
      d = {`RATE_EXP_ONE, 11'h226};
    end
    CMD <= '{1'b1, w, c, d};
  endtask : op
  task automatic idle();
    @(negedge SYS_CLK);
    CMD.valid <= 1'b0;
  endtask : idle
  // store new scale mantissa, then reload the whole image
  task automatic restore(input logic [10:0] man);
    @(negedge SYS_CLK);
    NVM.scale_man <= man;
    RESTORE <= 1'b1;
    @(negedge SYS_CLK);
    RESTORE <= 1'b0;
  endtask : restore
endmodule : pmbus_host_model

// ==== verif/converter_config_commands_tb.sv ====
// Purpose: self-checking bench for the converter configuration commands
// Assumes: inputs change on the falling edge, reads checked by a monitor
// Notes: read results queued at issue and matched in order
`timescale 1ns/100ps
`include "converter_config_consts.svh"
module converter_config_commands_tb;
  import converter_config_pkg::*;
  logic sys_clk = 1'b0, reset = 1'b1, conv_en = 1'b0, max_write = 1'b0, clear_faults = 1'b0;
  logic [15:0] target_req = 16'h0800, slew_step = 16'h0010, vout_max = 16'h1000, f;
  logic [15:0] rd_data, scale_word, vout_target, exp_q[$];
  logic rd_valid, alert, restore;
  div_tap_t div_tap;
  logic [3:0] rate_sel;
  logic [5:0] vin_code;
  status_t status;
  cmd_req_t cmd;
  nvm_t nvm;
  int miscompares = 0, samples_checked = 0;
  logic [10:0] sman[7] = '{11'h010, 11'h011, 11'h020, 11'h021, 11'h040, 11'h041, 11'h080};
  logic [15:0] stap[7] = '{16'h0, 16'h1, 16'h1, 16'h2, 16'h2, 16'h3, 16'h3};
  logic [15:0] rword[12] = '{16'h00f9, 16'h00fb, 16'h012d, 16'h015f, 16'h019b, 16'h01f5,
    16'h0259, 16'h02bd, 16'h0335, 16'h03e9, 16'h0a5d, 16'h0ac1};
  always #20 sys_clk = ~sys_clk;
  pmbus_host_model host (.SYS_CLK(sys_clk), .CMD(cmd), .NVM(nvm), .RESTORE(restore));
  converter_config_commands DUT (.SYS_CLK(sys_clk), .RESET(reset), .CMD(cmd), .NVM(nvm),
    .RESTORE(restore), .CONV_EN(conv_en), .TARGET_REQ(target_req), .SLEW_STEP(slew_step),
    .VOUT_MAX(vout_max), .MAX_WRITE(max_write), .CLEAR_FAULTS(clear_faults),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .DIV_TAP(div_tap), .SCALE_WORD(scale_word),
    .RATE_SEL(rate_sel), .VIN_CODE(vin_code), .VOUT_TARGET(vout_target), .STATUS(status),
    .ALERT(alert));
  task automatic close_out();
    if (exp_q.size() != 0) miscompares++;
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  task automatic cmp_hw(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_hw
  task automatic cmp_rd();
    cmp_hw(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 16'hdead);
  endtask : cmp_rd
  always @(negedge sys_clk) if (rd_valid === 1'b1) cmp_rd();
  function automatic logic [15:0] hw_now(input logic [7:0] c);
    case (c)
      `CMD_SCALE: return {14'h0, div_tap};
      `CMD_RATE: return {12'h0, rate_sel};
      default: return {10'h0, vin_code};
    endcase
  endfunction : hw_now
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    host.op(1'b0, c, 16'h0000);
    exp_q.push_back(e);
  endtask : rd
  task automatic apply(input logic [7:0] c, input logic [15:0] w, input logic [15:0] h);
    host.op(1'b1, c, w);
    rd(c, w);
    host.idle();
    cmp_hw(hw_now(c), h);
  endtask : apply
  task automatic clear();
    @(negedge sys_clk);
    clear_faults <= 1'b1;
    @(negedge sys_clk);
    clear_faults <= 1'b0;
    @(negedge sys_clk);
    cmp_hw({11'h0, status, alert}, 16'h0000);
  endtask : clear
  task automatic refuse(input logic [7:0] c, input logic [15:0] bad, input logic [15:0] old);
    logic [15:0] h;
    h = hw_now(c);
    host.op(1'b1, c, bad);
    rd(c, old);
    host.idle();
    cmp_hw({11'h0, status, alert}, 16'h0003);
    cmp_hw(hw_now(c), h);
    clear();
  endtask : refuse
  initial begin
    #200000;
    miscompares++;
    close_out();
  end
  initial begin
    void'($urandom(65));
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    reset <= 1'b0;
    @(negedge sys_clk);
    cmp_hw({14'h0, div_tap}, 16'h0002);
    cmp_hw(scale_word, 16'hc840);
    cmp_hw({12'h0, rate_sel}, 16'h0009);
    cmp_hw({10'h0, vin_code}, 16'h001e);
    rd(`CMD_SCALE, 16'hc840);
    rd(`CMD_RATE, 16'h0a26);
    rd(`CMD_INPUT_START_THRESHOLD, 16'hf028);
    rd(`CMD_FLOOR, 16'h0100);
    for (int i = 0; i < 7; i++) apply(`CMD_SCALE, {5'h19, sman[i]}, stap[i]);
    for (int i = 0; i < 12; i++) apply(`CMD_RATE, rword[i], 16'(i));
    apply(`CMD_INPUT_START_THRESHOLD, 16'hf00b, 16'h0001);
    apply(`CMD_INPUT_START_THRESHOLD, 16'hf03f, 16'h0035);
    apply(`CMD_INPUT_START_THRESHOLD, 16'he815, 16'h0000);
    refuse(`CMD_SCALE, 16'hc8c0, 16'hc880);
    refuse(`CMD_RATE, 16'h0b39, 16'h0ac1);
    refuse(`CMD_INPUT_START_THRESHOLD, 16'hf040, 16'he815);
    refuse(`CMD_FLOOR, 16'h1001, 16'h0100);
    refuse(8'h00, 16'h1234, 16'h0000);
    f = 16'($urandom) & 16'h07ff;
    host.op(1'b1, `CMD_FLOOR, f);
    rd(`CMD_FLOOR, f);
    host.op(1'b1, `CMD_FLOOR, 16'h0100);
    conv_en <= 1'b1;
    host.op(1'b1, `CMD_SCALE, 16'hc810);
    host.op(1'b1, `CMD_RATE, 16'h00f9);
    rd(`CMD_SCALE, 16'hc810);
    host.idle();
    cmp_hw({14'h0, div_tap}, 16'h0003);
    cmp_hw(scale_word, 16'hc880);
    cmp_hw({12'h0, rate_sel}, 16'h000b);
    host.restore(11'h010);
    cmp_hw({14'h0, div_tap}, 16'h0000);
    cmp_hw(scale_word, 16'hc810);
    cmp_hw({12'h0, rate_sel}, 16'h0009);
    rd(`CMD_SCALE, 16'hc810);
    host.idle();
    conv_en <= 1'b0;
    target_req <= 16'h0080;
    repeat (2) @(negedge sys_clk);
    cmp_hw(vout_target, 16'h0100);
    conv_en <= 1'b1;
    target_req <= 16'h0200;
    @(negedge sys_clk);
    cmp_hw(vout_target, 16'h0110);
    repeat (20) @(negedge sys_clk);
    cmp_hw(vout_target, 16'h0200);
    target_req <= 16'h0050;
    repeat (2) @(negedge sys_clk);
    cmp_hw({11'h0, status, alert}, 16'h001d);
    repeat (20) @(negedge sys_clk);
    cmp_hw(vout_target, 16'h0100);
    clear();
    vout_max <= 16'h0040;
    max_write <= 1'b1;
    @(negedge sys_clk);
    max_write <= 1'b0;
    @(negedge sys_clk);
    cmp_hw({11'h0, status, alert}, 16'h001d);
    vout_max <= 16'h1000;
    clear();
    host.op(1'b1, `CMD_FLOOR, 16'h0060);
    rd(`CMD_FLOOR, 16'h0060);
    host.idle();
    cmp_hw({11'h0, status, alert}, 16'h001d);
    repeat (3) @(negedge sys_clk);
    close_out();
  end
endmodule : converter_config_commands_tb
